// ==== rtl/asf_status.sv ====
// asf_status: converter status flags, result holding and apb registers
// asf_sat: full-scale clamp, one instance per result register, voltage and temperature sharing one
// assumes conversion and calibration events come from logic on pclk
// assumes paddr carries byte addresses, one word per register
//
// Contract
// (RULE1) calibration end sets status bit 15
// (RULE2) mode/filter/current-control write clears bit 15
// (RULE3) voltage/temperature out-of-range sets bit 13
// (RULE4) out-of-range result saturates to full scale
// (RULE5) in-range stored v/t result clears bit 13
// (RULE6) current out-of-range sets bit 12
// (RULE7) in-range stored current result clears bit 12
// (RULE8) software ignores unused bits 11 to 6
// (RULE9) every current conversion sets bit 5
// (RULE10) bit 5 works only with mode enable
// (RULE11) current result read clears bits 5, 0
// (RULE12) current magnitude above threshold sets bit 4
// (RULE13) threshold flag only with comparator enabled
// (RULE14) any reconfiguration clears threshold flag
// (RULE15) stored temperature result sets bit 2
// (RULE16) stored voltage result sets bit 1
// (RULE17) stored current result sets bit 0
// (RULE18) calibration end sets enabled ready flags
// (RULE19) either result read clears bits 2, 1
// (RULE20) bits 7 to 0 masked, ored into interrupt
// (RULE21) results held until ready flags cleared; code stores new results regardless while core_down is high
// (RULE22) software sets mode bit 5, default 0
// (RULE23) reserved status bits read as zero
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module asf_status
  import asf_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asf_pkg::ADDR_W-1:0] paddr,
  input wire logic [asf_pkg::DATA_W-1:0] pwdata,
  output logic [asf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter datapath events
  input wire logic cal_done,
  input wire asf_pkg::asf_cur_evt_s cur_evt,
  input wire asf_pkg::asf_vt_evt_s vt_evt,
  input wire logic core_down,
  // outputs
  output logic adc_irq,
  output logic [7:0] mode_out,
  output logic [15:0] filter_out,
  output logic [15:0] cur_ctrl_out
);
  import asf_pkg::*;

  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic [7:0] mask_ff;
  logic [7:0] mode_ff;
  logic [15:0] filter_ff;
  logic [15:0] cur_ctrl_ff;
  logic [15:0] thresh_ff;
  logic [7:0] config_ff;
  logic [15:0] cur_res_ff;
  logic [15:0] vt_res_ff;
  logic [31:0] prdata_ff;
  logic irq_ff;

  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic wr_mode;
  logic wr_filter;
  logic wr_cur_ctrl;
  logic wr_config;
  logic wr_thresh;
  logic wr_mask;
  logic reconfig;
  logic rd_cur;
  logic rd_vt;
  logic cur_en;
  logic volt_en;
  logic temp_en;
  logic cmp_en;
  logic [15:0] cur_sat;
  logic [15:0] vt_sat;
  logic cur_ok;
  logic vt_ok;
  logic cur_store;
  logic vt_store;
  logic [16:0] cur_mag;
  logic [31:0] rd_mux;

  // apb phases
  assign setup = psel & ~penable;
  assign access = psel & penable & ce;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;

  always_comb
  begin
    unique case (paddr)
      OFS_STATUS, OFS_MASK, OFS_MODE, OFS_FILTER,
      OFS_CUR_CTRL, OFS_VT_RES, OFS_CUR_RES,
      OFS_THRESH, OFS_CONFIG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign wr_mode = wr & (paddr == OFS_MODE);
  assign wr_filter = wr & (paddr == OFS_FILTER);
  assign wr_cur_ctrl = wr & (paddr == OFS_CUR_CTRL);
  assign wr_config = wr & (paddr == OFS_CONFIG);
  assign wr_thresh = wr & (paddr == OFS_THRESH);
  assign wr_mask = wr & (paddr == OFS_MASK);
  assign rd_cur = rd & (paddr == OFS_CUR_RES);
  assign rd_vt = rd & (paddr == OFS_VT_RES);
  assign reconfig = wr_mode | wr_filter | wr_cur_ctrl | wr_config;

  assign cur_en = config_ff[CFG_CUR_EN];
  assign volt_en = config_ff[CFG_VOLT_EN];
  assign temp_en = config_ff[CFG_TEMP_EN];
  assign cmp_en = config_ff[CFG_CMP_EN];

  // saturation of out-of-range results
  asf_sat u_sat_cur
  (
    .raw(cur_evt.data),
    .over(cur_evt.over),
    .under(cur_evt.under),
    .clamped(cur_sat)
  );

  asf_sat u_sat_vt
  (
    .raw(vt_evt.data),
    .over(vt_evt.over),
    .under(vt_evt.under),
    .clamped(vt_sat)
  );

  // result registers accept data once ready flags are clear, or at any time while core_down is high
  // bit 5 counts as a ready flag of the current result
  assign cur_ok = ~status_ff[ST_CUR_RDY] & ~status_ff[ST_CONT];
  assign vt_ok = ~status_ff[ST_TEMP_RDY] & ~status_ff[ST_VOLT_RDY];
  assign cur_store = cur_evt.valid & cur_en & (cur_ok | core_down); // [RULE21]
  assign vt_store = vt_evt.valid & (vt_evt.is_temp ? temp_en : volt_en)
                    & (vt_ok | core_down); // [RULE21]

  // magnitude of the clamped current value, 17 bits for negative full scale
  assign cur_mag = cur_sat[RES_W-1] ? (17'h0_0000 - {cur_sat[RES_W-1], cur_sat})
                                    : {1'b0, cur_sat};

  // current result register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_res_ff <= RES_RST;
    else if (ce && cur_store)
      cur_res_ff <= cur_sat;
  end

  // voltage/temperature result register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vt_res_ff <= RES_RST;
    else if (ce && vt_store)
      vt_res_ff <= vt_sat;
  end

  // status flag update: clears first, then sets so a set wins, reserved and unused bits forced to zero at the end
  always_comb
  begin
    nxt_status = status_ff;
    if (wr_mode | wr_filter | wr_cur_ctrl)
      nxt_status[ST_CAL] = 1'b0; // [RULE2]
    if (reconfig)
      nxt_status[ST_THR] = 1'b0; // [RULE14]
    if (rd_cur)
    begin
      nxt_status[ST_CONT] = 1'b0; // [RULE11]
      nxt_status[ST_CUR_RDY] = 1'b0; // [RULE11]
      nxt_status[ST_TEMP_RDY] = 1'b0; // [RULE19]
      nxt_status[ST_VOLT_RDY] = 1'b0; // [RULE19]
    end
    if (rd_vt)
    begin
      nxt_status[ST_TEMP_RDY] = 1'b0; // [RULE19]
      nxt_status[ST_VOLT_RDY] = 1'b0; // [RULE19]
      // current channel off: a v/t read also clears ready bit 0, bit 5 is left as it is
      if (!cur_en)
        nxt_status[ST_CUR_RDY] = 1'b0;
    end
    if (!mode_ff[MODE_CONT_EN])
      nxt_status[ST_CONT] = 1'b0; // [RULE10]
    if (!cmp_en)
      nxt_status[ST_THR] = 1'b0; // [RULE13]
    if (cur_store && !(cur_evt.over || cur_evt.under))
      nxt_status[ST_CUR_ERR] = 1'b0; // [RULE7]
    if (vt_store && !(vt_evt.over || vt_evt.under))
      nxt_status[ST_VT_ERR] = 1'b0; // [RULE5]
    // sets
    if (cal_done)
    begin
      nxt_status[ST_CAL] = 1'b1; // [RULE1]
      if (cur_en)
        nxt_status[ST_CUR_RDY] = 1'b1; // [RULE18]
      if (volt_en)
        nxt_status[ST_VOLT_RDY] = 1'b1; // [RULE18]
      if (temp_en)
        nxt_status[ST_TEMP_RDY] = 1'b1; // [RULE18]
    end
    if (cur_evt.valid && cur_en)
    begin
      if (cur_evt.over || cur_evt.under)
        nxt_status[ST_CUR_ERR] = 1'b1; // [RULE6]
      if (mode_ff[MODE_CONT_EN])
        nxt_status[ST_CONT] = 1'b1; // [RULE9] [RULE10]
      if (cmp_en && (cur_mag > {1'b0, thresh_ff}))
        nxt_status[ST_THR] = 1'b1; // [RULE12] [RULE13]
    end
    if (vt_evt.valid && (vt_evt.is_temp ? temp_en : volt_en)
        && (vt_evt.over || vt_evt.under))
      nxt_status[ST_VT_ERR] = 1'b1; // [RULE3]
    if (cur_store)
      nxt_status[ST_CUR_RDY] = 1'b1; // [RULE17]
    if (vt_store && vt_evt.is_temp)
      nxt_status[ST_TEMP_RDY] = 1'b1; // [RULE15]
    if (vt_store && !vt_evt.is_temp)
      nxt_status[ST_VOLT_RDY] = 1'b1; // [RULE16]
    // reserved and unused bits never hold a one
    nxt_status[ST_RSVD_HI] = 1'b0; // [RULE23]
    nxt_status[ST_UNUSED_HI:ST_UNUSED_LO] = '0; // [RULE23] [RULE8]
    nxt_status[ST_RSVD_LO] = 1'b0; // [RULE23]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_ff <= STATUS_RST;
    else if (ce)
      status_ff <= nxt_status;
  end

  // software-written control registers, one flop group each
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_ff <= MASK_RST;
    else if (ce && wr_mask)
      mask_ff <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_ff <= MODE_RST; // [RULE22]
    else if (ce && wr_mode)
      mode_ff <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      filter_ff <= FILTER_RST;
    else if (ce && wr_filter)
      filter_ff <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ctrl_ff <= CUR_CTRL_RST;
    else if (ce && wr_cur_ctrl)
      cur_ctrl_ff <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      thresh_ff <= THRESH_RST;
    else if (ce && wr_thresh)
      thresh_ff <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_ff <= CONFIG_RST;
    else if (ce && wr_config)
      config_ff <= pwdata[7:0];
  end

  // interrupt from low status byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_ff <= 1'b0;
    else if (ce)
      irq_ff <= |(nxt_status[IRQ_W-1:0] & mask_ff); // [RULE20]
  end

  // read data captured in the setup cycle
  always_comb
  begin
    rd_mux = ZERO_W;
    unique case (paddr)
      OFS_STATUS: rd_mux = {16'h0000, status_ff};
      OFS_MASK: rd_mux = {24'h00_0000, mask_ff};
      OFS_MODE: rd_mux = {24'h00_0000, mode_ff};
      OFS_FILTER: rd_mux = {16'h0000, filter_ff};
      OFS_CUR_CTRL: rd_mux = {16'h0000, cur_ctrl_ff};
      OFS_VT_RES: rd_mux = {16'h0000, vt_res_ff};
      OFS_CUR_RES: rd_mux = {16'h0000, cur_res_ff};
      OFS_THRESH: rd_mux = {16'h0000, thresh_ff};
      OFS_CONFIG: rd_mux = {24'h00_0000, config_ff};
      default: rd_mux = ZERO_W;
    endcase
  end

  // loaded at setup so the read clear at the access edge cannot race it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= ZERO_W;
    else if (ce && setup && !pwrite)
      prdata_ff <= rd_mux;
  end

  assign prdata = prdata_ff;
  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;
  assign adc_irq = irq_ff;
  assign mode_out = mode_ff;
  assign filter_out = filter_ff;
  assign cur_ctrl_out = cur_ctrl_ff;
endmodule : asf_status

// asf_sat: clamps one conversion result to full scale on a range error
module asf_sat
  import asf_pkg::*;
#(
  parameter int unsigned W = asf_pkg::RES_W,
  parameter logic [W-1:0] FULL_POS = asf_pkg::POS_FULL,
  parameter logic [W-1:0] FULL_NEG = asf_pkg::NEG_FULL
)
(
  // raw result and range flags
  input wire logic [W-1:0] raw,
  input wire logic over,
  input wire logic under,
  // value to store
  output logic [W-1:0] clamped
);
  import asf_pkg::*;

  // over wins when both flags are up
  always_comb
  begin
    clamped = raw;
    if (over)
      clamped = FULL_POS; // [RULE4]
    else if (under)
      clamped = FULL_NEG; // [RULE4]
  end
endmodule : asf_sat
`default_nettype wire

// ==== inc/asf_pkg.sv ====
// asf_pkg: constants and carriers of the converter status block
// assumes 32-bit apb, byte offsets, system clock domain only
package asf_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RES_W = 16;
  // register byte offsets
  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_MASK = 6'h04;
  localparam logic [5:0] OFS_MODE = 6'h08;
  localparam logic [5:0] OFS_FILTER = 6'h0C;
  localparam logic [5:0] OFS_CUR_CTRL = 6'h10;
  localparam logic [5:0] OFS_VT_RES = 6'h14;
  localparam logic [5:0] OFS_CUR_RES = 6'h18;
  localparam logic [5:0] OFS_THRESH = 6'h1C;
  localparam logic [5:0] OFS_CONFIG = 6'h20;
  // status bit positions
  localparam int unsigned ST_CAL = 15;
  localparam int unsigned ST_VT_ERR = 13;
  localparam int unsigned ST_CUR_ERR = 12;
  localparam int unsigned ST_CONT = 5;
  localparam int unsigned ST_THR = 4;
  localparam int unsigned ST_TEMP_RDY = 2;
  localparam int unsigned ST_VOLT_RDY = 1;
  localparam int unsigned ST_CUR_RDY = 0;
  // reserved and unused status positions
  localparam int unsigned ST_RSVD_HI = 14;
  localparam int unsigned ST_UNUSED_HI = 11;
  localparam int unsigned ST_UNUSED_LO = 6;
  localparam int unsigned ST_RSVD_LO = 3;
  localparam int unsigned IRQ_W = 8;
  // control bit positions
  localparam int unsigned MODE_CONT_EN = 5;
  localparam int unsigned CFG_CUR_EN = 0;
  localparam int unsigned CFG_VOLT_EN = 1;
  localparam int unsigned CFG_TEMP_EN = 2;
  localparam int unsigned CFG_CMP_EN = 3;
  // reset values and full-scale codes
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] FILTER_RST = 16'h0000;
  localparam logic [15:0] CUR_CTRL_RST = 16'h0000;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [15:0] RES_RST = 16'h0000;
  localparam logic [15:0] POS_FULL = 16'h7FFF;
  localparam logic [15:0] NEG_FULL = 16'h8000;
  localparam logic [31:0] ZERO_W = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic over;
    logic under;
    logic [15:0] data;
  } asf_cur_evt_s;

  typedef struct packed {
    logic valid;
    logic over;
    logic under;
    logic is_temp;
    logic [15:0] data;
  } asf_vt_evt_s;
endpackage : asf_pkg

// ==== tb/asf_status_monitor.sv ====
// asf_status_monitor: port-level checks on the status block
// assumes bound onto asf_status, single pclk domain
`timescale 1ns/1ps
`default_nettype none
module asf_status_monitor
  import asf_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asf_pkg::ADDR_W-1:0] paddr,
  input wire logic [asf_pkg::DATA_W-1:0] pwdata,
  input wire logic [asf_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // control copies
  input wire logic [7:0] mode_out,
  input wire logic [15:0] filter_out,
  input wire logic [15:0] cur_ctrl_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && ce;
  pready_ce_a: assert property (pready == ce) else $error("pready not equal to ce");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  err_unmap_a: assert property (acc && paddr > OFS_CONFIG |-> pslverr && (pwrite || prdata == ZERO_W))
    else $error("unmapped access not refused");
  status_rsvd_a: assert property (acc && !pwrite && paddr == OFS_STATUS |->
    prdata[31:16] == 16'h0000 && !prdata[14] && prdata[11:6] == 6'h00 && !prdata[3])
    else $error("reserved status bit set");
  mode_wr_a: assert property (acc && pwrite && paddr == OFS_MODE |=> mode_out == $past(pwdata[7:0]))
    else $error("mode copy wrong");
  filter_wr_a: assert property (acc && pwrite && paddr == OFS_FILTER |=> filter_out == $past(pwdata[15:0]))
    else $error("filter copy wrong");
  ctrl_wr_a: assert property (acc && pwrite && paddr == OFS_CUR_CTRL |=> cur_ctrl_out == $past(pwdata[15:0]))
    else $error("control copy wrong");
  freeze_a: assert property (!ce |=> $stable(mode_out) && $stable(filter_out) && $stable(cur_ctrl_out))
    else $error("state moved with ce low");
endmodule : asf_status_monitor
`default_nettype wire

// ==== tb/test_adc_status_flags.sv ====
// test_adc_status_flags: directed bench for the converter status block
// assumes asf_status on 25 MHz pclk, apb answering with pready
`timescale 1ns/1ps
`default_nettype none
module test_adc_status_flags;
  import asf_pkg::*;
  typedef struct packed {logic [5:0] a; logic [15:0] e;} asf_row_s;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cal_done = 1'b0, core_down = 1'b0, adc_irq, pready, pslverr;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [7:0] mode_out;
  logic [15:0] filter_out, cur_ctrl_out;
  asf_cur_evt_s cur_evt = '0;
  asf_vt_evt_s vt_evt = '0;
  int mismatches = 0, n_checks = 0;
  // all ones written, masked readback expected
  asf_row_s rows [9] = '{'{OFS_STATUS, 16'h0000}, '{OFS_VT_RES, 16'h0000}, '{OFS_MASK, 16'h00FF},
    '{OFS_MODE, 16'h00FF}, '{OFS_FILTER, 16'hFFFF}, '{OFS_CUR_CTRL, 16'hFFFF}, '{OFS_THRESH, 16'hFFFF},
    '{OFS_CONFIG, 16'h00FF}, '{6'h24, 16'h0000}};
  asf_status u_asf_status (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_done(cal_done), .cur_evt(cur_evt), .vt_evt(vt_evt), .core_down(core_down), .adc_irq(adc_irq),
    .mode_out(mode_out), .filter_out(filter_out), .cur_ctrl_out(cur_ctrl_out));
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic [5:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    logic [31:0] q;
    apb(a, 1'b0, ZERO_W, q);
    chk($sformatf("reg %h", a), {16'h0000, e}, q);
  endtask : rd
  task automatic cur(input logic [15:0] d, input logic o, input logic u);
    @(posedge pclk);
    cur_evt <= '{1'b1, o, u, d};
    @(posedge pclk);
    cur_evt <= '0;
  endtask : cur
  task automatic vt(input logic t, input logic [15:0] d, input logic o, input logic u);
    @(posedge pclk);
    vt_evt <= '{1'b1, o, u, t, d};
    @(posedge pclk);
    vt_evt <= '0;
  endtask : vt
  task automatic cal;
    @(posedge pclk);
    cal_done <= 1'b1;
    @(posedge pclk);
    cal_done <= 1'b0;
  endtask : cal
  task automatic irq(input logic e);
    repeat (2) @(posedge pclk);
    chk("adc_irq", {31'h0, e}, {31'h0, adc_irq});
  endtask : irq
  // a few hundred cycles expected, generous margin
  initial
  begin
    #(40 * 20000);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a, 16'h0000);
      wr(rows[i].a, 32'hFFFF_FFFF);
      rd(rows[i].a, rows[i].e);
    end
    wr(OFS_CONFIG, 32'h0000_000F);
    wr(OFS_MODE, 32'h0000_0020);
    wr(OFS_THRESH, 32'h0000_0100);
    cal();
    rd(OFS_STATUS, 16'h8007);
    irq(1'b1);
    rd(OFS_CUR_RES, 16'h0000);
    rd(OFS_STATUS, 16'h8000);
    irq(1'b0);
    wr(OFS_FILTER, 32'h0000_0000);
    rd(OFS_STATUS, 16'h0000);
    cur(16'h1234, 1'b1, 1'b0);
    rd(OFS_STATUS, 16'h1031);
    rd(OFS_CUR_RES, 16'h7FFF);
    cur(16'h0050, 1'b0, 1'b0);
    rd(OFS_STATUS, 16'h0031);
    cur(16'h0060, 1'b0, 1'b0);
    rd(OFS_CUR_RES, 16'h0050);
    cur(16'h0070, 1'b0, 1'b0);
    core_down <= 1'b1;
    cur(16'h0080, 1'b0, 1'b0);
    core_down <= 1'b0;
    rd(OFS_CUR_RES, 16'h0080);
    rd(OFS_STATUS, 16'h0010);
    vt(1'b0, 16'h0444, 1'b0, 1'b1);
    rd(OFS_STATUS, 16'h2012);
    rd(OFS_VT_RES, 16'h8000);
    rd(OFS_STATUS, 16'h2010);
    vt(1'b1, 16'h0123, 1'b0, 1'b0);
    rd(OFS_STATUS, 16'h0014);
    rd(OFS_CUR_RES, 16'h0080);
    rd(OFS_STATUS, 16'h0010);
    wr(OFS_CONFIG, 32'h0000_0007);
    rd(OFS_STATUS, 16'h0000);
    wr(OFS_MODE, 32'h0000_0000);
    cur(16'h7000, 1'b0, 1'b0);
    rd(OFS_STATUS, 16'h0001);
    wr(OFS_MASK, 32'h0000_00FE);
    irq(1'b0);
    @(posedge pclk);
    ce <= 1'b0;
    cal();
    ce <= 1'b1;
    rd(OFS_STATUS, 16'h0001);
    cal();
    wr(OFS_CUR_CTRL, 32'h0000_1234);
    rd(OFS_STATUS, 16'h0007);
    rd(OFS_CUR_CTRL, 16'h1234);
    chk("cur_ctrl_out", 32'h0000_1234, {16'h0000, cur_ctrl_out});
    cal();
    wr(OFS_MODE, 32'h0000_0020);
    rd(OFS_STATUS, 16'h0007);
    wr(OFS_MASK, 32'h0000_00FF);
    irq(1'b1);
    // mid-run reset returns every register to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("adc_irq", ZERO_W, {31'h0, adc_irq});
    chk("mode_out", ZERO_W, {24'h00_0000, mode_out});
    chk("cur_ctrl_out", ZERO_W, {16'h0000, cur_ctrl_out});
    presetn <= 1'b1;
    rd(OFS_STATUS, 16'h0000);
    rd(OFS_MASK, 16'h0000);
    end_of_test();
  end
endmodule : test_adc_status_flags
bind asf_status asf_status_monitor u_asf_status_monitor (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mode_out(mode_out), .filter_out(filter_out), .cur_ctrl_out(cur_ctrl_out));
`default_nettype wire
